// *** core/rif_pkg.sv ***
// Package of offsets, field positions and defaults for the flag logic
package rif_pkg;
  // ****************************************************
  // Register map (byte addresses on the SRAM-style bus)
  // ****************************************************
  localparam logic [14:0] ADDR_FLAGS   = 15'h7ff0;  // Event flags, read clears
  localparam logic [14:0] ADDR_IRQ_EN  = 15'h7ff6;  // Interrupt enables
  localparam logic [14:0] ADDR_WD_CTRL = 15'h7ff7;  // Watchdog control
  localparam logic [14:0] ADDR_TEST    = 15'h7ffc;  // Holds frequency test bit
  localparam logic [14:0] ADDR_CTRL    = 15'h7ff8;  // Holds latch bits
  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int FLAG_WD_BIT    = 7;  // Watchdog flag
  localparam int FLAG_ALARM_BIT = 6;  // Alarm flag
  localparam int FLAG_BATT_BIT  = 4;  // Battery low flag
  localparam int EN_ALARM_BIT   = 7;  // Alarm interrupt enable
  localparam int EN_BACKUP_BIT  = 5;  // Back-up alarm enable
  localparam int WD_ROUTE_BIT   = 7;  // Watchdog route select
  localparam int TEST_FT_BIT    = 6;  // Frequency test enable
  localparam int CTRL_W_BIT     = 7;  // Write latch
  localparam int CTRL_R_BIT     = 6;  // Read latch
  // ****************************************************
  // Defaults
  // ****************************************************
  localparam logic [7:0] BYTE_ZERO = 8'h00;  // Cleared byte
  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_PERIOD_NS   = 100;  // Clock period
  localparam int ADDR_STABLE_NS  = 15;   // Least address hold for clear
  localparam int ADDR_STABLE_CYC =
    (ADDR_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
    (ADDR_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************************
  // Power sequencing states
  // ****************************************************
  typedef enum logic [1:0] {
    RIF_PWR_OFF,
    RIF_PWR_CHECK,
    RIF_PWR_ON
  } rif_pwr_t;
endpackage

// *** core/rif_sync2.sv ***
// Two flip-flop synchroniser for pin inputs
module rif_sync2 #(
  parameter int W = 1
) (
  // Clock and control
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic         i_ce,
  // Data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_q;  // First stage, read only by second stage

  // Two stages, frozen with the clock enable
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      meta_q <= '0;
      o_q    <= '0;
    end else if (i_ce) begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule

// *** core/rif_hold_cnt.sv ***
// Counter that reports a level held for a least number of cycles
module rif_hold_cnt #(
  parameter int N = 1
) (
  // Clock and control
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_ce,
  // Level and result
  input  wire logic i_lvl,
  output logic      o_met
);
  localparam int CW = $clog2(N + 1);
  localparam logic [CW-1:0] CMAX = CW'(N);
  logic [CW-1:0] cnt_q;  // Cycles the level has stood

  // Count up while the level stands, saturate at the limit
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cnt_q <= '0;
      o_met <= 1'b0;
    end else if (i_ce) begin
      if (!i_lvl) begin
        cnt_q <= '0;
        o_met <= 1'b0;
      end else if (cnt_q != CMAX) begin
        cnt_q <= cnt_q + CW'(1);
        o_met <= (cnt_q + CW'(1)) == CMAX;
      end
    end
  end
endmodule

// *** core/rif_top.sv ***
// Interrupt, flag and power-state default logic of the clock/SRAM device
// Summary of operation
// - Alarm or watchdog events set their flags
// - Pin driven only by enabled interrupt sources or frequency test
// - Flags read clears alarm flag, releases pin
// - Pin released unless interrupt or test mode
// - Battery checked at every power-up
// - Battery low flag reads at D4
// - Battery low sticks until passing check
// - Check only with main supply present
// - Power-up clears enables, watchdog, latches, test
// - First power-up leaves other bits undefined
// - Later power-up keeps other bits unchanged
// - Power-down clears latches, test, watchdog; keeps enables
// - Back-up alarm needs both enable bits
// - Flags read also clears watchdog flag
// - Route select picks pin or reset pulse
// - Interrupt outranks frequency test output
module rif_top (
  // Clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  // SRAM-style bus pins (active low strobes)
  input  wire logic [14:0] i_addr,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  output logic      [7:0]  o_data,
  output logic             o_data_oe,
  // Events from timekeeping logic (same clock)
  input  wire logic        i_alarm_evt,
  input  wire logic        i_wd_timeout,
  input  wire logic        i_ft_square,
  // Supply status pins
  input  wire logic        i_vcc_good,
  input  wire logic        i_batt_low,
  // Open-drain interrupt/test pin, enable high pulls low
  output logic             o_irq_freqtest_pin_o,
  output logic             o_irq_freqtest_pin_oe,
  // Watchdog reset request and control bits to the rest of the device
  output logic             o_wd_rst_pulse,
  output logic      [4:0]  o_wd_multiplier,
  output logic      [1:0]  o_wd_resolution,
  output logic             o_write_latch,
  output logic             o_read_latch
);
  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [14:0] addr_s;       // Synchronised address
  logic [7:0]  data_s;       // Synchronised write data
  logic [2:0]  strb_n_s;     // Synchronised strobes: ce, oe, we
  logic [1:0]  pwr_s;        // Synchronised vcc good, battery low

  rif_sync2 #(.W(15)) u_sync_addr (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_ce   (i_ce),
    .i_d    (i_addr),
    .o_q    (addr_s)
  );
  rif_sync2 #(.W(8)) u_sync_data (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_ce   (i_ce),
    .i_d    (i_data),
    .o_q    (data_s)
  );
  rif_sync2 #(.W(3)) u_sync_strb (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_ce   (i_ce),
    .i_d    ({i_ce_n, i_oe_n, i_we_n}),
    .o_q    (strb_n_s)
  );
  rif_sync2 #(.W(2)) u_sync_pwr (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_ce   (i_ce),
    .i_d    ({i_vcc_good, i_batt_low}),
    .o_q    (pwr_s)
  );

  wire vcc_ok    = pwr_s[1];   // Main supply present
  wire batt_weak = pwr_s[0];   // Comparator says battery weak

  // ****************************************************
  // Bus decode
  // ****************************************************
  wire rd_cyc = !strb_n_s[2] && !strb_n_s[1] && strb_n_s[0];
  wire wr_cyc = !strb_n_s[2] && !strb_n_s[0];
  logic wr_prev_q;             // Write strobe seen last cycle
  wire wr_stb = wr_cyc && !wr_prev_q && vcc_ok;   // One write per strobe

  // Address match decode, used for reads and writes
  function automatic logic hit(input logic [14:0] a, input logic [14:0] r);
    hit = (a == r);
  endfunction

  wire flag_sel  = hit(addr_s, rif_pkg::ADDR_FLAGS);
  wire wr_en_reg = wr_stb && hit(addr_s, rif_pkg::ADDR_IRQ_EN);
  wire wr_wd_reg = wr_stb && hit(addr_s, rif_pkg::ADDR_WD_CTRL);
  wire wr_test   = wr_stb && hit(addr_s, rif_pkg::ADDR_TEST);
  wire wr_ctrl   = wr_stb && hit(addr_s, rif_pkg::ADDR_CTRL);

  // Clear only after the address has stood at the flags location
  // in a read for the least hold; shorter glitches do nothing
  logic flag_rd_held;          // Hold met this cycle
  logic flag_rd_done_q;        // Clear already issued for this read
  rif_hold_cnt #(.N(rif_pkg::ADDR_STABLE_CYC)) u_hold (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_ce   (i_ce),
    .i_lvl  (rd_cyc && flag_sel && vcc_ok),
    .o_met  (flag_rd_held)
  );
  wire flag_clr = flag_rd_held && !flag_rd_done_q;

  // ****************************************************
  // Power sequencing
  // ****************************************************
  rif_pkg::rif_pwr_t pwr_q;    // Power state
  wire pwr_up   = (pwr_q == rif_pkg::RIF_PWR_OFF) && vcc_ok;
  wire pwr_down = (pwr_q != rif_pkg::RIF_PWR_OFF) && !vcc_ok;

  // Off until supply returns, one check cycle, then on
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pwr_q <= rif_pkg::RIF_PWR_OFF;
    end else if (i_ce) begin
      unique case (pwr_q)
        rif_pkg::RIF_PWR_OFF:   if (vcc_ok) pwr_q <= rif_pkg::RIF_PWR_CHECK;
        rif_pkg::RIF_PWR_CHECK: pwr_q <= vcc_ok ? rif_pkg::RIF_PWR_ON
                                                : rif_pkg::RIF_PWR_OFF;
        rif_pkg::RIF_PWR_ON:    if (!vcc_ok) pwr_q <= rif_pkg::RIF_PWR_OFF;
      endcase
    end
  end

  // Battery check runs only in the check state, with main supply up
  wire batt_check = (pwr_q == rif_pkg::RIF_PWR_CHECK) && vcc_ok;

  // ****************************************************
  // Control registers
  // ****************************************************
  logic       alarm_irq_enable_q;     // Alarm interrupt enable
  logic       backup_alarm_enable_q;  // Alarm in back-up mode enable
  logic [7:0] wd_ctrl_q;              // Route, multiplier, resolution
  logic       freq_test_enable_q;     // Frequency test mode
  logic       wlatch_q;               // Write latch bit
  logic       rlatch_q;               // Read latch bit
  logic [5:0] en_other_q;             // Other bits of enable byte
  logic [6:0] test_other_q;           // Other bits of test byte
  logic [5:0] ctrl_other_q;           // Other bits of control byte

  // Kept bits: no reset, so first power-up leaves them undefined
  // and reset or a later power-up leaves them untouched
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (wr_en_reg) en_other_q <= {data_s[6], data_s[4:0]};
      if (wr_test) test_other_q <= {data_s[7], data_s[5:0]};
      if (wr_ctrl) ctrl_other_q <= data_s[5:0];
    end
  end

  // Defaulted bits: cleared at reset and power-up, selected at power-down
  always_ff @(posedge i_clk) begin
    if (!i_rstn || (i_ce && pwr_up)) begin
      alarm_irq_enable_q    <= 1'b0;
      backup_alarm_enable_q <= 1'b0;
      wd_ctrl_q             <= rif_pkg::BYTE_ZERO;
      freq_test_enable_q    <= 1'b0;
      wlatch_q              <= 1'b0;
      rlatch_q              <= 1'b0;
    end else if (i_ce && pwr_down) begin
      // Enables keep their value so the back-up alarm still works
      wd_ctrl_q          <= rif_pkg::BYTE_ZERO;
      freq_test_enable_q <= 1'b0;
      wlatch_q           <= 1'b0;
      rlatch_q           <= 1'b0;
    end else if (i_ce) begin
      if (wr_en_reg) begin
        alarm_irq_enable_q    <= data_s[rif_pkg::EN_ALARM_BIT];
        backup_alarm_enable_q <= data_s[rif_pkg::EN_BACKUP_BIT];
      end
      if (wr_wd_reg) wd_ctrl_q <= data_s;
      if (wr_test) freq_test_enable_q <= data_s[rif_pkg::TEST_FT_BIT];
      if (wr_ctrl) begin
        wlatch_q <= data_s[rif_pkg::CTRL_W_BIT];
        rlatch_q <= data_s[rif_pkg::CTRL_R_BIT];
      end
      // A reset-routed timeout clears the watchdog and enables
      if (i_wd_timeout && wd_ctrl_q[rif_pkg::WD_ROUTE_BIT]) begin
        wd_ctrl_q          <= rif_pkg::BYTE_ZERO;
        freq_test_enable_q <= 1'b0;
        alarm_irq_enable_q    <= 1'b0;
        backup_alarm_enable_q <= 1'b0;
      end
    end
  end

  wire wd_route = wd_ctrl_q[rif_pkg::WD_ROUTE_BIT];   // Watchdog route select

  // ****************************************************
  // Flags
  // ****************************************************
  logic alarm_flag_q;          // Alarm flag
  logic watchdog_flag_q;       // Watchdog flag
  logic battery_low_flag_q;    // Battery low flag
  logic wd_irq_q;              // Watchdog pin request, cleared by write

  // Events win over a read clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      alarm_flag_q    <= 1'b0;
      watchdog_flag_q <= 1'b0;
      wd_irq_q        <= 1'b0;
      flag_rd_done_q  <= 1'b0;
      wr_prev_q       <= 1'b0;
    end else if (i_ce) begin
      wr_prev_q      <= wr_cyc;
      flag_rd_done_q <= flag_rd_held;
      if (i_alarm_evt) alarm_flag_q <= 1'b1;
      else if (flag_clr) alarm_flag_q <= 1'b0;
      if (i_wd_timeout) watchdog_flag_q <= 1'b1;
      else if (flag_clr) watchdog_flag_q <= 1'b0;
      // Pin-routed timeout holds until a read or a watchdog write
      if (i_wd_timeout && !wd_route) wd_irq_q <= 1'b1;
      else if (flag_clr || wr_wd_reg) wd_irq_q <= 1'b0;
    end
  end

  // Battery flag has no reset: it must survive a reset or power-down
  always_ff @(posedge i_clk) begin
    if (i_ce && batt_check) begin
      battery_low_flag_q <= batt_weak;
    end
  end

  // ****************************************************
  // Pin and read data
  // ****************************************************
  wire backup   = (pwr_q != rif_pkg::RIF_PWR_ON);
  wire alarm_on = alarm_flag_q && alarm_irq_enable_q &&
                  (!backup || backup_alarm_enable_q);
  wire wd_on    = wd_irq_q && !wd_route && !backup;
  wire irq_on   = alarm_on || wd_on;
  // Test tone only in normal mode, with alarm interrupt disabled and watchdog on reset route or all zero
  wire ft_on    = freq_test_enable_q && !alarm_irq_enable_q && !backup &&
                  (wd_route || wd_ctrl_q == rif_pkg::BYTE_ZERO);
  wire pin_low  = irq_on || (ft_on && !i_ft_square);

  wire [7:0] flags_rd = {watchdog_flag_q, alarm_flag_q, 1'b0,
                         battery_low_flag_q, 4'h0};
  wire [7:0] en_rd    = {alarm_irq_enable_q, en_other_q[5],
                         backup_alarm_enable_q, en_other_q[4:0]};
  wire [7:0] test_rd  = {test_other_q[6], freq_test_enable_q,
                         test_other_q[5:0]};
  wire [7:0] ctrl_rd  = {wlatch_q, rlatch_q, ctrl_other_q};
  // Other addresses belong to the memory array and read as zero here
  wire [7:0] rd_mux =
    flag_sel                               ? flags_rd  :
    hit(addr_s, rif_pkg::ADDR_IRQ_EN)      ? en_rd     :
    hit(addr_s, rif_pkg::ADDR_WD_CTRL)     ? wd_ctrl_q :
    hit(addr_s, rif_pkg::ADDR_TEST)        ? test_rd   :
    hit(addr_s, rif_pkg::ADDR_CTRL)        ? ctrl_rd   :
                                             rif_pkg::BYTE_ZERO;

  // Registered outputs
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_data                <= rif_pkg::BYTE_ZERO;
      o_data_oe             <= 1'b0;
      o_irq_freqtest_pin_o  <= 1'b0;
      o_irq_freqtest_pin_oe <= 1'b0;
      o_wd_rst_pulse        <= 1'b0;
      o_wd_multiplier       <= 5'h0;
      o_wd_resolution       <= 2'h0;
      o_write_latch         <= 1'b0;
      o_read_latch          <= 1'b0;
    end else if (i_ce) begin
      o_data                <= rd_mux;
      o_data_oe             <= rd_cyc && vcc_ok;
      o_irq_freqtest_pin_o  <= 1'b0;
      o_irq_freqtest_pin_oe <= pin_low;
      o_wd_rst_pulse        <= i_wd_timeout && wd_route;
      o_wd_multiplier       <= wd_ctrl_q[6:2];
      o_wd_resolution       <= wd_ctrl_q[1:0];
      o_write_latch         <= wlatch_q;
      o_read_latch          <= rlatch_q;
    end
  end
endmodule

// *** sim/rif_top_assertions.sv ***
// Concurrent checks on the ports of the interrupt and flag logic
module rif_top_assertions (
  // ****************************************************
  // Clock, reset and bus pins
  // ****************************************************
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic [14:0] i_addr,
  input wire logic        i_ce_n,
  input wire logic        i_oe_n,
  input wire logic        i_we_n,
  input wire logic [7:0]  o_data,
  input wire logic        o_data_oe,
  // Events and supply
  input wire logic        i_alarm_evt,
  input wire logic        i_wd_timeout,
  input wire logic        i_ft_square,
  input wire logic        i_vcc_good,
  // Pin and control outputs
  input wire logic        o_irq_freqtest_pin_o,
  input wire logic        o_irq_freqtest_pin_oe,
  input wire logic        o_wd_rst_pulse,
  input wire logic [4:0]  o_wd_multiplier,
  input wire logic [1:0]  o_wd_resolution,
  input wire logic        o_write_latch,
  input wire logic        o_read_latch
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ****************************************************
  // Named steps
  // ****************************************************
  // Host holds a read of the flag byte with main supply present
  wire flag_rd = !i_ce_n && !i_oe_n && i_we_n && i_vcc_good &&
                 (i_addr == rif_pkg::ADDR_FLAGS);
  // Quiet read: no new event and no test toggle may re-arm the pin
  wire quiet_rd = flag_rd && i_ft_square && !i_alarm_evt && !i_wd_timeout;
  sequence flag_read_s;
    flag_rd [*4];
  endsequence
  sequence clear_read_s;
    quiet_rd [*7];
  endsequence
  sequence vcc_lost_s;
    (!i_vcc_good) [*4];
  endsequence
  // ****************************************************
  // Properties
  // ****************************************************
  a_pin_open_drain: assert property (o_irq_freqtest_pin_o == 1'b0)
    else $error("pin output level not low");
  a_rst_pulse_one: assert property (o_wd_rst_pulse |=> !o_wd_rst_pulse)
    else $error("reset pulse longer than a cycle");
  a_rst_pulse_cause: assert property (
    $rose(o_wd_rst_pulse) |-> $past(i_wd_timeout))
    else $error("reset pulse without timeout");
  a_rst_clears_ctrl: assert property (
    o_wd_rst_pulse |=> (o_wd_multiplier == 5'h00 && o_wd_resolution == 2'h0))
    else $error("watchdog control kept after reset pulse");
  a_pwr_down_clear: assert property (
    vcc_lost_s |=> (!o_write_latch && !o_read_latch &&
                    o_wd_multiplier == 5'h00))
    else $error("latches or watchdog kept at power-down");
  a_reset_defaults: assert property (
    $rose(i_rstn) |-> (!o_write_latch && !o_read_latch &&
                       !o_irq_freqtest_pin_oe && o_wd_multiplier == 5'h00))
    else $error("defaults missing after reset");
  a_flag_read_layout: assert property (
    flag_read_s |-> (o_data_oe && o_data[3:0] == 4'h0 && !o_data[5]))
    else $error("flag read not answered or unused bits set");
  a_read_clears_pin: assert property (
    clear_read_s |-> !o_irq_freqtest_pin_oe)
    else $error("pin still low after flag read");
endmodule
bind rif_top rif_top_assertions chk_u (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_ce_n(i_ce_n),
  .i_oe_n(i_oe_n), .i_we_n(i_we_n), .o_data(o_data),
  .o_data_oe(o_data_oe), .i_alarm_evt(i_alarm_evt),
  .i_wd_timeout(i_wd_timeout), .i_ft_square(i_ft_square),
  .i_vcc_good(i_vcc_good), .o_irq_freqtest_pin_o(o_irq_freqtest_pin_o),
  .o_irq_freqtest_pin_oe(o_irq_freqtest_pin_oe),
  .o_wd_rst_pulse(o_wd_rst_pulse), .o_wd_multiplier(o_wd_multiplier),
  .o_wd_resolution(o_wd_resolution), .o_write_latch(o_write_latch),
  .o_read_latch(o_read_latch)
);

// *** sim/rif_host_model.sv ***
// Host processor model driving the SRAM-style bus
module rif_host_model (
  // Clock and answer from the device
  input  wire logic        i_clk,
  input  wire logic [7:0]  i_rd_data,
  input  wire logic        i_rd_oe,
  // Bus pins driven by the host
  output logic      [14:0] o_addr,
  output logic      [7:0]  o_wr_data,
  output logic             o_ce_n,
  output logic             o_oe_n,
  output logic             o_we_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus with all strobes high
  initial begin
    o_addr    = 15'h0000;
    o_wr_data = 8'h00;
    o_ce_n    = 1'b1;
    o_oe_n    = 1'b1;
    o_we_n    = 1'b1;
  end
  // One write strobe; lines inverted after so stale values never match
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr    = a;
    o_wr_data = d;
    o_ce_n    = 1'b0;
    o_we_n    = 1'b0;
    repeat (4) @(negedge i_clk);
    o_ce_n    = 1'b1;
    o_we_n    = 1'b1;
    o_addr    = ~a;
    o_wr_data = ~d;
    repeat (3) @(negedge i_clk);
  endtask
  // Read; ok stays low when the device never drives the bus
  task automatic rd(input logic [14:0] a, output logic [7:0] d,
                    output bit ok);
    int n;
    @(negedge i_clk);
    o_addr = a;
    o_ce_n = 1'b0;
    o_oe_n = 1'b0;
    n  = 0;
    ok = 1'b0;
    while (n < 8 && !ok) begin
      @(posedge i_clk);
      ok = (i_rd_oe === 1'b1);
      n++;
    end
    d = i_rd_data;
    // Address held well past the clear point of a flag read
    repeat (4) @(negedge i_clk);
    o_ce_n = 1'b1;
    o_oe_n = 1'b1;
    o_addr = ~a;
    repeat (3) @(negedge i_clk);
  endtask
endmodule

// *** sim/rif_top_tb.sv ***
// Self-checking bench for the interrupt and flag logic
module rif_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rstn, ce, alm, wdt, sq, vcc, bat;
  logic [14:0] addr;
  logic [7:0]  wdat, rdat;
  logic        ce_n, oe_n, we_n, doe, pin_o, pin_oe, rstp, wl, rl;
  logic [4:0]  mult;
  logic [1:0]  res;
  int          error_cnt, checks_done, cyc, pulses;
  rif_top dut_u (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_addr(addr),
    .i_data(wdat), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
    .o_data(rdat), .o_data_oe(doe), .i_alarm_evt(alm),
    .i_wd_timeout(wdt), .i_ft_square(sq), .i_vcc_good(vcc),
    .i_batt_low(bat), .o_irq_freqtest_pin_o(pin_o),
    .o_irq_freqtest_pin_oe(pin_oe), .o_wd_rst_pulse(rstp),
    .o_wd_multiplier(mult), .o_wd_resolution(res),
    .o_write_latch(wl), .o_read_latch(rl));
  rif_host_model host_u (.i_clk(clk), .i_rd_data(rdat), .i_rd_oe(doe),
    .o_addr(addr), .o_wr_data(wdat), .o_ce_n(ce_n), .o_oe_n(oe_n),
    .o_we_n(we_n));
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Cycle ceiling and reset pulse counter
  always @(posedge clk) begin
    cyc++;
    if (rstp === 1'b1) pulses++;
    if (cyc == 8000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask
  // A refused read yields xx, so only a refusal can match xx
  task automatic rdchk(input logic [14:0] a, input logic [7:0] e);
    logic [7:0] d;
    bit         ok;
    host_u.rd(a, d, ok);
    check(ok ? d : 8'hxx, e);
  endtask
  // One-cycle event pulse, then time for flag and pin to land
  task automatic fire(input bit wd);
    @(negedge clk);
    if (wd) wdt = 1'b1;
    else alm = 1'b1;
    @(negedge clk);
    wdt = 1'b0;
    alm = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    {rstn, alm, wdt, bat} = 4'h0;
    {ce, sq, vcc} = 3'h7;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    rdchk(rif_pkg::ADDR_FLAGS, 8'h00);
    chk1(pin_oe, 1'b0);
    // Alarm routed, then cleared by a flag read
    host_u.wr(rif_pkg::ADDR_IRQ_EN, 8'h80);
    host_u.wr(rif_pkg::ADDR_WD_CTRL, 8'h00);
    fire(1'b0);
    chk1(pin_oe, 1'b1);
    rdchk(rif_pkg::ADDR_FLAGS, 8'h40);
    chk1(pin_oe, 1'b0);
    rdchk(rif_pkg::ADDR_FLAGS, 8'h00);
    // Alarm not enabled: flag only
    host_u.wr(rif_pkg::ADDR_IRQ_EN, 8'h00);
    fire(1'b0);
    chk1(pin_oe, 1'b0);
    rdchk(rif_pkg::ADDR_FLAGS, 8'h40);
    // Watchdog steered to the pin
    host_u.wr(rif_pkg::ADDR_WD_CTRL, 8'h0e);
    check({1'b0, mult, res}, 8'h0e);
    fire(1'b1);
    chk1(pin_oe, 1'b1);
    rdchk(rif_pkg::ADDR_FLAGS, 8'h80);
    chk1(pin_oe, 1'b0);
    // Watchdog steered to the reset pulse
    host_u.wr(rif_pkg::ADDR_WD_CTRL, 8'h8e);
    pulses = 0;
    fire(1'b1);
    check(8'(pulses), 8'h01);
    chk1(pin_oe, 1'b0);
    check({1'b0, mult, res}, 8'h00);
    rdchk(rif_pkg::ADDR_FLAGS, 8'h80);
    // Frequency test and its suppression
    host_u.wr(rif_pkg::ADDR_TEST, 8'h40);
    sq = 1'b0;
    repeat (3) @(negedge clk);
    chk1(pin_oe, 1'b1);
    sq = 1'b1;
    repeat (3) @(negedge clk);
    chk1(pin_oe, 1'b0);
    sq = 1'b0;
    host_u.wr(rif_pkg::ADDR_IRQ_EN, 8'h80);
    chk1(pin_oe, 1'b0);
    host_u.wr(rif_pkg::ADDR_IRQ_EN, 8'h00);
    host_u.wr(rif_pkg::ADDR_WD_CTRL, 8'h0e);
    chk1(pin_oe, 1'b0);
    host_u.wr(rif_pkg::ADDR_WD_CTRL, 8'h00);
    chk1(pin_oe, 1'b1);
    sq = 1'b1;
    // Power-down without back-up alarm enable
    host_u.wr(rif_pkg::ADDR_CTRL, 8'hc5);
    check({6'h00, wl, rl}, 8'h03);
    host_u.wr(rif_pkg::ADDR_IRQ_EN, 8'h80);
    host_u.wr(rif_pkg::ADDR_WD_CTRL, 8'h0e);
    vcc = 1'b0;
    repeat (5) @(negedge clk);
    check({1'b0, mult, wl, rl}, 8'h00);
    fire(1'b0);
    chk1(pin_oe, 1'b0);
    rdchk(rif_pkg::ADDR_FLAGS, 8'hxx);
    bat = 1'b1;
    vcc = 1'b1;
    repeat (8) @(negedge clk);
    rdchk(rif_pkg::ADDR_FLAGS, 8'h50);
    rdchk(rif_pkg::ADDR_IRQ_EN, 8'h00);
    rdchk(rif_pkg::ADDR_WD_CTRL, 8'h00);
    rdchk(rif_pkg::ADDR_TEST, 8'h00);
    rdchk(rif_pkg::ADDR_CTRL, 8'h05);
    // Battery flag sticks while powered, then back-up alarm
    bat = 1'b0;
    rdchk(rif_pkg::ADDR_FLAGS, 8'h10);
    host_u.wr(rif_pkg::ADDR_IRQ_EN, 8'ha0);
    vcc = 1'b0;
    repeat (5) @(negedge clk);
    fire(1'b0);
    chk1(pin_oe, 1'b1);
    vcc = 1'b1;
    repeat (8) @(negedge clk);
    chk1(pin_oe, 1'b0);
    rdchk(rif_pkg::ADDR_FLAGS, 8'h40);
    // Reset in mid-run keeps the other control bits
    host_u.wr(rif_pkg::ADDR_CTRL, 8'hc5);
    host_u.wr(rif_pkg::ADDR_IRQ_EN, 8'hff);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    check({6'h00, wl, rl}, 8'h00);
    rdchk(rif_pkg::ADDR_CTRL, 8'h05);
    rdchk(rif_pkg::ADDR_IRQ_EN, 8'h5f);
    rdchk(15'h0100, 8'h00);
    // Clock enable low freezes state, so an event then is lost
    ce = 1'b0;
    fire(1'b0);
    ce = 1'b1;
    rdchk(rif_pkg::ADDR_FLAGS, 8'h00);
    report_and_stop();
  end
endmodule
